// File: sar_adc_pkg.sv
// Purpose: constants and types shared by the converter control block
// Assumes: one machine cycle is a fixed number of aclk cycles
// Notes:   register word offsets are byte addresses on axi4-lite
`default_nettype none

package sar_adc_pkg;
   // byte offsets
   localparam logic [7:0] off_control     = 8'h00;
   localparam logic [7:0] off_result_high = 8'h04;
   localparam logic [7:0] off_irq_status  = 8'h08;
   localparam logic [7:0] off_irq_clear   = 8'h0c;
   localparam logic [7:0] off_irq_enable  = 8'h10;
   localparam logic [7:0] off_power       = 8'h14;
   // control register fields
   localparam int pos_chan      = 0;
   localparam int pos_start     = 3;
   localparam int pos_done      = 4;
   localparam int pos_ext_en    = 5;
   localparam int pos_res_lo    = 6;
   // power register fields
   localparam int pos_idle      = 0;
   localparam int pos_pdown     = 1;
   // reset values
   localparam logic [31:0] rst_word = 32'h0000_0000;
   // timing in machine cycles, aclk cycles per machine cycle, axi response codes
   localparam int mc_init       = 2;
   localparam int mc_sample     = 8;
   localparam int mc_per_bit    = 4;
   localparam int mc_total_full = 50;
   localparam int mc_total_red  = 24;
   localparam int clk_per_mc    = 12;
   localparam logic [1:0] axi_okay   = 2'b00;
   localparam logic [1:0] axi_slverr = 2'b10;

   typedef enum {st_idle, st_init, st_sample, st_conv, st_tail} phase_t;

   typedef struct packed {
      logic       awready;
      logic       wready;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic       aw_held;
      logic [7:0] aw_addr;
      logic       w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
   } bus_state_t;
endpackage

`default_nettype wire

// File: sar_adc_ctrl.sv
// Purpose: sequencing of a successive approximation converter
// Assumes: comparator output is asynchronous; start pin asynchronous
// Notes:   all state is one struct registered by one always_ff
`default_nettype none

module sar_adc_ctrl
   import sar_adc_pkg::*;
#(
   parameter int res_bits   = 10,
   parameter int total_mc   = mc_total_full,
   parameter int mc_clocks  = clk_per_mc
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic          ext_start_pin,
   input  wire logic          comp_above,
   output logic [res_bits-1:0] dac_code,
   output logic [2:0]         mux_select,
   output logic               sample_en,
   output logic               irq
);

   localparam int tail_mc = total_mc - mc_init - mc_sample
                            - mc_per_bit * res_bits;
   localparam int cw = 8;

   typedef struct packed {
      bus_state_t          bus;
      phase_t              phase;
      logic [cw-1:0]       clk_cnt;
      logic [cw-1:0]       mc_cnt;
      logic [3:0]          bit_idx;
      logic [res_bits-1:0] sar;
      logic [res_bits-1:0] result;
      logic                cmd;
      logic                start_status;
      logic                done;
      logic                ext_en;
      logic [2:0]          chan;
      logic [2:0]          chan_held;
      logic                idle_mode;
      logic                pdown_mode;
      logic                pin_q1;
      logic                pin_q2;
      logic                pin_prev_mc;
      logic                comp_q1;
      logic                comp_q2;
      logic [1:0]          irq_status;
      logic [1:0]          irq_enable;
      logic                irq;
      logic                sample_en;
   } state_t;

   state_t st;
   state_t next_st;

   // ------------------------------------------------------------
   // register read mux
   // ------------------------------------------------------------
   function automatic logic [31:0] read_word(input state_t s,
                                             input logic [7:0] a);
      logic [31:0] v;
      logic [res_bits-1:0] r;
      v = 32'h0000_0000;
      r = s.result;
      case (a)
         off_control: begin
            v[pos_chan +: 3] = s.chan;
            v[pos_start]     = s.start_status;
            v[pos_done]      = s.done;
            v[pos_ext_en]    = s.ext_en;
            if (res_bits > 8) begin
               v[pos_res_lo +: 2] = r[1:0];
            end
         end
         off_result_high: v[7:0] = r[res_bits-1 -: 8];
         off_irq_status:  v[1:0] = s.irq_status;
         off_irq_enable:  v[1:0] = s.irq_enable;
         off_power: begin
            v[pos_idle]  = s.idle_mode;
            v[pos_pdown] = s.pdown_mode;
         end
         default:         v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return a == off_control || a == off_result_high ||
             a == off_irq_status || a == off_irq_clear ||
             a == off_irq_enable || a == off_power;
   endfunction

   logic mc_end;
   assign mc_end = (st.clk_cnt == cw'(mc_clocks - 1));

   always_comb begin
      logic        wr_go;
      logic        pin_edge;
      logic        start_req;
      logic        done_set;
      logic        abort;
      logic        finish;
      logic [31:0] wd;
      logic [1:0]  clr;
      next_st   = st;
      wr_go     = 1'b0;
      pin_edge  = 1'b0;
      start_req = 1'b0;
      done_set  = 1'b0;
      abort     = 1'b0;
      finish    = 1'b0;
      wd        = st.bus.w_data;
      clr       = 2'b00;

      next_st.pin_q1  = ext_start_pin;
      next_st.pin_q2  = st.pin_q1;
      next_st.comp_q1 = comp_above;
      next_st.comp_q2 = st.comp_q1;

      // -----------------------------------------------------------
      // machine cycle timebase
      // -----------------------------------------------------------
      next_st.clk_cnt = mc_end ? '0 : st.clk_cnt + 1'b1;

      // -----------------------------------------------------------
      // axi4-lite slave
      // -----------------------------------------------------------
      next_st.bus.awready = 1'b0;
      next_st.bus.wready  = 1'b0;
      next_st.bus.arready = 1'b0;
      if (!st.bus.aw_held && s_axi_awvalid && !st.bus.awready) begin
         next_st.bus.awready = 1'b1;
         next_st.bus.aw_held = 1'b1;
         next_st.bus.aw_addr = s_axi_awaddr;
      end
      if (!st.bus.w_held && s_axi_wvalid && !st.bus.wready) begin
         next_st.bus.wready = 1'b1;
         next_st.bus.w_held = 1'b1;
         next_st.bus.w_data = s_axi_wdata;
         next_st.bus.w_strb = s_axi_wstrb;
      end
      if (st.bus.aw_held && st.bus.w_held && !st.bus.bvalid) begin
         wr_go              = 1'b1;
         next_st.bus.bvalid = 1'b1;
         next_st.bus.bresp  = addr_ok(st.bus.aw_addr) ? axi_okay
                                                      : axi_slverr;
         next_st.bus.aw_held = 1'b0;
         next_st.bus.w_held  = 1'b0;
      end
      if (st.bus.bvalid && s_axi_bready) begin
         next_st.bus.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !st.bus.arready && !st.bus.rvalid) begin
         next_st.bus.arready = 1'b1;
         next_st.bus.rvalid  = 1'b1;
         next_st.bus.rdata   = read_word(st, s_axi_araddr);
         next_st.bus.rresp   = addr_ok(s_axi_araddr) ? axi_okay
                                                     : axi_slverr;
      end
      if (st.bus.rvalid && s_axi_rready) begin
         next_st.bus.rvalid = 1'b0;
      end

      // -----------------------------------------------------------
      // register writes
      // -----------------------------------------------------------
      if (wr_go && st.bus.w_strb[0]) begin
         case (st.bus.aw_addr)
            off_control: begin
               next_st.chan   = wd[pos_chan +: 3];
               next_st.ext_en = wd[pos_ext_en];
               if (!wd[pos_done]) begin
                  next_st.done = 1'b0;
               end
               if (wd[pos_start] && st.phase == st_idle) begin
                  next_st.cmd = 1'b1;
               end
            end
            off_irq_clear:  clr = wd[1:0];
            off_irq_enable: next_st.irq_enable = wd[1:0];
            off_power: begin
               next_st.idle_mode  = wd[pos_idle];
               next_st.pdown_mode = wd[pos_pdown];
            end
            default: ;
         endcase
      end

      // -----------------------------------------------------------
      // start detection at machine cycle boundaries
      // -----------------------------------------------------------
      if (mc_end) begin
         next_st.pin_prev_mc = st.pin_q2;
         // low at the last boundary, high at this one
         pin_edge = !st.pin_prev_mc && st.pin_q2;
      end
      if (mc_end && st.phase == st_idle && !st.idle_mode
          && !st.pdown_mode) begin
         start_req = st.cmd || (st.ext_en && pin_edge);
      end

      // -----------------------------------------------------------
      // conversion sequencer, one step per machine cycle
      // -----------------------------------------------------------
      abort = next_st.idle_mode || next_st.pdown_mode;
      case (st.phase)
         st_idle: begin
            if (start_req) begin
               next_st.phase  = st_init;
               next_st.mc_cnt = '0;
               next_st.cmd    = 1'b1;
            end
         end
         st_init: begin
            if (mc_end) begin
               next_st.mc_cnt = st.mc_cnt + 1'b1;
               if (st.mc_cnt == '0) begin
                  next_st.start_status = 1'b1;
               end
               if (st.mc_cnt == cw'(mc_init - 1)) begin
                  next_st.phase     = st_sample;
                  next_st.chan_held = st.chan;
                  next_st.sample_en = 1'b1;
                  next_st.mc_cnt    = '0;
               end
            end
         end
         st_sample: begin
            if (mc_end) begin
               next_st.mc_cnt = st.mc_cnt + 1'b1;
               if (st.mc_cnt == cw'(mc_sample - 1)) begin
                  next_st.phase     = st_conv;
                  next_st.sample_en = 1'b0;
                  next_st.sar       = '0;
                  next_st.sar[res_bits-1] = 1'b1;
                  next_st.bit_idx   = 4'(res_bits - 1);
                  next_st.mc_cnt    = '0;
               end
            end
         end
         st_conv: begin
            if (mc_end) begin
               next_st.mc_cnt = st.mc_cnt + 1'b1;
               if (st.mc_cnt == cw'(mc_per_bit - 1)) begin
                  next_st.mc_cnt = '0;
                  next_st.sar[st.bit_idx] = st.comp_q2;
                  if (st.bit_idx == '0 && tail_mc > 0) begin
                     next_st.phase = st_tail;
                  end else if (st.bit_idx == '0) begin
                     // last trial ends exactly on the total count
                     finish = 1'b1;
                  end else begin
                     next_st.bit_idx = st.bit_idx - 1'b1;
                     next_st.sar[st.bit_idx - 1'b1] = 1'b1;
                  end
               end
            end
         end
         st_tail: begin
            if (mc_end) begin
               next_st.mc_cnt = st.mc_cnt + 1'b1;
               if (st.mc_cnt >= cw'(tail_mc > 0 ? tail_mc - 1 : 0)) begin
                  finish = 1'b1;
               end
            end
         end
         default: next_st.phase = st_idle;
      endcase
      if (finish) begin
         next_st.phase        = st_idle;
         next_st.start_status = 1'b0;
         next_st.cmd          = 1'b0;
         next_st.done         = 1'b1;
         done_set             = 1'b1;
         if (!st.done) begin
            next_st.result = next_st.sar;
         end
      end
      if (abort && st.phase != st_idle) begin
         // done flag is left as it was; result too, unless the last trial finishes in this same cycle
         next_st.phase        = st_idle;
         next_st.start_status = 1'b0;
         next_st.cmd          = 1'b0;
         next_st.sample_en    = 1'b0;
         next_st.done         = st.done;
         done_set             = 1'b0;
      end

      // -----------------------------------------------------------
      // interrupts: bit0 done, bit1 abort; set beats clear
      // -----------------------------------------------------------
      next_st.irq_status = (st.irq_status & ~clr)
                           | {abort && st.phase != st_idle, done_set};
      next_st.irq = |(next_st.irq_status & next_st.irq_enable);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st       <= '0;
         st.phase <= st_idle;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.bus.awready;
   assign s_axi_wready  = st.bus.wready;
   assign s_axi_bvalid  = st.bus.bvalid;
   assign s_axi_bresp   = st.bus.bresp;
   assign s_axi_arready = st.bus.arready;
   assign s_axi_rvalid  = st.bus.rvalid;
   assign s_axi_rresp   = st.bus.rresp;
   assign s_axi_rdata   = st.bus.rdata;
   assign dac_code      = st.sar;
   assign mux_select    = st.chan_held;
   assign sample_en     = st.sample_en;
   assign irq           = st.irq;

endmodule // sar_adc_ctrl

`default_nettype wire

// File: sar_adc_ctrl_asserts.sv
// Purpose: port-level checks for sar_adc_ctrl
// Assumes: 12 aclk cycles per machine cycle
// Notes:   bound to every instance of sar_adc_ctrl
`default_nettype none

module sar_adc_ctrl_asserts
   import sar_adc_pkg::*;
#(
   parameter int res_bits = 10
) (
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wready,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic [res_bits-1:0] dac_code,
   input wire logic [2:0]          mux_select,
   input wire logic                sample_en
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ----------------------------------------
   // helper: length of the sampling window
   // ----------------------------------------
   logic [7:0] run_len;
   always_ff @(posedge aclk) begin
      if (!aresetn || !sample_en) begin
         run_len <= 8'h00;
      end else begin
         run_len <= run_len + 8'h01;
      end
   end

   sequence rd_answer;
      s_axi_arready && s_axi_rvalid;
   endsequence
   sequence msb_loaded;
      ##[0:12] dac_code == {1'b1, {(res_bits-1){1'b0}}};
   endsequence

   awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   wready_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
      else $error("wready longer than one cycle");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("bvalid dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   read_answer_a: assert property ($rose(s_axi_arvalid) |=> rd_answer)
      else $error("read not answered next cycle");
   sample_len_a: assert property ($fell(sample_en) |-> run_len == 8'h60)
      else $error("sampling not eight machine cycles");
   mux_steady_a: assert property ($past(sample_en) && sample_en
      |-> $stable(mux_select)) else $error("channel moved while sampling");
   msb_load_a: assert property ($fell(sample_en) |-> msb_loaded)
      else $error("approximation not started at top bit");
endmodule // sar_adc_ctrl_asserts

bind sar_adc_ctrl sar_adc_ctrl_asserts #(.res_bits(res_bits)) chk_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .dac_code(dac_code), .mux_select(mux_select), .sample_en(sample_en));

`default_nettype wire

// File: adc_far_side.sv
// Purpose: comparator and external trigger source model
// Assumes: analog input held steady by the bench during a conversion
// Notes:   a trig pulse gives 24 clocks low, then high until the next one
`default_nettype none

module adc_far_side (
   input wire logic       aclk,
   input wire logic [9:0] vin,
   input wire logic       trig,
   input wire logic [9:0] dac_code,
   output logic           comp_above,
   output var logic       ext_start_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int low_left = 0;

   // above only when strictly greater
   assign comp_above = vin > dac_code;

   // low for two machine cycles so one whole one is always covered
   initial ext_start_pin = 1'h1;
   always @(posedge aclk) begin
      if (trig) begin
         low_left <= 24;
      end else if (low_left > 0) begin
         low_left <= low_left - 1;
      end
      ext_start_pin <= !(trig || low_left > 1);
   end
endmodule // adc_far_side

`default_nettype wire

// File: tb_sar_adc_conversion_control.sv
// Purpose: self-checking bench for sar_adc_ctrl
// Assumes: default parameters, 12 clocks per machine cycle
// Notes:   far side is adc_far_side; checker comes by bind
`default_nettype none

module tb_sar_adc_conversion_control;
   import sar_adc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'h0, aresetn = 1'h0, trig = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, r, br;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        ext_start_pin, comp_above, sample_en, irq;
   logic [9:0]  vin = 10'h000, dac_code, res;
   logic [2:0]  mux_select;
   int          n_fail = 0, samples_checked = 0, cyc = 0, seed = 4674;

   always #2 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;

   sar_adc_ctrl dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ext_start_pin(ext_start_pin),
      .comp_above(comp_above), .dac_code(dac_code),
      .mux_select(mux_select), .sample_en(sample_en), .irq(irq));
   adc_far_side far (.aclk(aclk), .vin(vin), .trig(trig),
      .dac_code(dac_code), .comp_above(comp_above),
      .ext_start_pin(ext_start_pin));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      br = bresp;
      bready <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask

   function automatic logic [9:0] sar(input logic [9:0] v);
      logic [9:0] c;
      c = 10'h000;
      for (int b = 9; b >= 0; b--) begin
         c[b] = 1'h1;
         if (!(v > c)) c[b] = 1'h0;
      end
      return c;
   endfunction

   task automatic conv(input logic [2:0] ch, input logic [9:0] v,
                       input logic ext);
      int c0;
      vin <= v;
      res = sar(v);
      wr(off_control, {26'h0, ext, 2'h0, ch});
      if (ext) begin
         trig <= 1'h1;
         @(posedge aclk);
         trig <= 1'h0;
         c0 = cyc + 25;
      end else begin
         wr(off_control, {26'h0, 3'h1, ch});
         c0 = cyc;
      end
      @(posedge sample_en);
      @(negedge aclk);
      chk(mux_select, ch);
      rd(off_control);
      chk(d[pos_start], 1'h1);
      wr(off_control, {26'h0, 3'h1, ~ch});
      do rd(off_control);
      while (d[pos_done] !== 1'h1);
      chk(cyc - c0 >= 596 && cyc - c0 <= 632, 1'h1);
      chk(d[pos_start], 1'h0);
      chk(d[7:6], res[1:0]);
      rd(off_result_high);
      chk(d[7:0], res[9:2]);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      rd(off_control);
      chk(d, rst_word);
      rd(8'h18);
      chk(d, 32'h0);
      chk(r, axi_slverr);
      wr(8'h18, 32'hff);
      chk(br, axi_slverr);
      for (int i = 0; i < 6; i++) begin
         wr(off_irq_enable, {31'h0, i[0]});
         conv(3'($random(seed)), i == 0 ? 10'h000 : i == 1 ? 10'h3ff
              : 10'($random(seed)), i[1]);
         @(negedge aclk);
         chk(irq, i[0]);
         rd(off_irq_status);
         chk(d[0], 1'h1);
         wr(off_irq_clear, 32'h3);
         @(negedge aclk);
         @(negedge aclk);
         chk(irq, 1'h0);
      end
      wr(off_power, 32'h1);
      repeat (30) @(posedge aclk);
      rd(off_result_high);
      chk(d[7:0], res[9:2]);
      rd(off_control);
      chk(d[pos_done], 1'h1);
      wr(off_power, 32'h0);
      vin <= res ^ 10'h2aa;
      wr(off_control, 32'h18);
      repeat (700) @(posedge aclk);
      rd(off_result_high);
      chk(d[7:0], res[9:2]);
      wr(off_control, 32'h0);
      @(posedge aclk);
      trig <= 1'h1;
      @(posedge aclk);
      trig <= 1'h0;
      repeat (80) @(posedge aclk);
      rd(off_control);
      chk(d[pos_start], 1'h0);
      wr(off_control, 32'h8);
      @(negedge sample_en);
      repeat (100) @(posedge aclk);
      wr(off_power, 32'h2);
      repeat (700) @(posedge aclk);
      rd(off_control);
      chk(d[pos_done], 1'h0);
      rd(off_irq_status);
      chk(d[1], 1'h1);
      wr(off_power, 32'h0);
      end_of_test();
   end

   // about three times the expected run length
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      end_of_test();
   end
endmodule // tb_sar_adc_conversion_control

`default_nettype wire
